/* File: hdl/pdsp_pkg.sv */
// Purpose: shared constants and types for the source policy state engine
// Assumes: single 20 MHz clock
// Notes: timer figures are plain defaults, overridable at the top module
package pdsp_pkg;

	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TIMER_W = 32;
	localparam int unsigned HR_COUNT_W = 4;

	// interval lengths in microseconds
	localparam int unsigned SOURCE_TRANSITION_DELAY_US = 25;
	localparam int unsigned HARD_RESET_SUPPLY_US = 25000;
	localparam int unsigned NO_REPLY_US = 5000000;
	localparam int unsigned REPLY_WAIT_US = 30000;
	localparam int unsigned IDENTITY_DISCOVERY_US = 45000;

	// least times, rounded up to whole cycles
	localparam int unsigned SOURCE_TRANSITION_DELAY_CYC =
		(SOURCE_TRANSITION_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HARD_RESET_SUPPLY_CYC =
		(HARD_RESET_SUPPLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint unsigned NO_REPLY_CYC =
		(longint'(NO_REPLY_US) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REPLY_WAIT_CYC =
		(REPLY_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IDENTITY_DISCOVERY_CYC =
		(IDENTITY_DISCOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// policy manager evaluation outcomes
	localparam logic [1:0] EVAL_CAN_MEET = 2'h0;
	localparam logic [1:0] EVAL_CANNOT_MEET = 2'h1;
	localparam logic [1:0] EVAL_MEET_LATER = 2'h2;

	typedef enum logic [11:0] {
		src_startup_state = 12'h001,
		src_send_caps_state = 12'h002,
		src_negotiate_state = 12'h004,
		src_supply_transition_state = 12'h008,
		src_ready_state = 12'h010,
		src_disabled_state = 12'h020,
		src_cap_response_state = 12'h040,
		src_hard_reset_state = 12'h080,
		src_hard_reset_rcvd_state = 12'h100,
		src_return_default_state = 12'h200,
		src_query_sink_caps_state = 12'h400,
		src_wait_new_caps_state = 12'h800
	} pdsp_state_e;

	typedef enum logic [3:0] {
		msg_none = 4'h0,
		msg_source_caps = 4'h1,
		msg_accept = 4'h2,
		msg_reject = 4'h3,
		msg_wait = 4'h4,
		msg_goto_min = 4'h5,
		msg_ps_rdy = 4'h6,
		msg_get_sink_cap = 4'h7,
		msg_ping = 4'h8
	} pdsp_msg_e;

endpackage

/* File: hdl/pdsp_timer.sv */
// Purpose: loadable down-counter with a one-cycle timeout pulse
// Assumes: load and stop come from logic on the same clock
// Notes: load wins over stop; a load of zero never expires
`timescale 1ns/100ps
`default_nettype none
module pdsp_timer #(
	parameter int unsigned W = 32
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic load,
	input wire logic stop,
	input wire logic [W-1:0] load_val,
	output logic running,
	output logic expired
);
	logic [W-1:0] count;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (load) begin
				count <= load_val;
				running <= (load_val != '0);
			end else if (stop) begin
				running <= 1'b0;
			end else if (running) begin
				count <= count - 1'b1;
				if (count == {{(W-1){1'b0}}, 1'b1}) begin
					running <= 1'b0;
					expired <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_timer_single_pulse;
		expired |=> !expired;
	endproperty
	a_timer_single_pulse: assert property (p_timer_single_pulse)
		else $error("timer timeout lasted more than one cycle");

endmodule
`default_nettype wire

/* File: hdl/pdsp_engine.sv */
// Purpose: source port policy engine, states after a sink request arrives
// Assumes: all inputs come from logic on the same clock; events are one-cycle pulses
// Notes: outputs are registered; entry actions change in the cycle the state is entered, Ping, supply request and timeouts later
// Overview of operation
// - negotiate entry asks manager to evaluate request
// - unmeetable request goes to capability response
// - send GotoMin or Accept, wait, request supply
// - supply ready goes ready sending PS_RDY
// - ready entry ends sequence unless error pending
// - ready entry starts identity timer when needed
// - changed caps or Get_Source_Cap resend capabilities
// - manager minimum-power request reenters supply transition
// - manager sink-caps request enters query state
// - ready holds power, serves requests, sends Ping
// - disabled ignores messages except hard reset
// - Reject if unmeetable or invalid, else Wait
// - explicit contract: Wait or valid Reject returns ready
// - explicit contract, Reject, invalid: hard reset
// - no contract: wait for new capabilities
// - hard reset: signal, start timer, count up
// - no-reply timer survives state changes
// - detected hard reset enters received state
// - return-default entry resets supply, hardware, conductor
// - return-default exit restores power, reports completion
// - query sends Get_Sink_Cap, waits, reports outcome
// - wait state leaves only on changed capabilities or detected hard reset
`timescale 1ns/100ps
`default_nettype none
module pdsp_engine #(
	parameter int unsigned SRC_TRANS_CYC = pdsp_pkg::SOURCE_TRANSITION_DELAY_CYC,
	parameter int unsigned HR_SUPPLY_CYC = pdsp_pkg::HARD_RESET_SUPPLY_CYC,
	parameter longint unsigned NO_REPLY_CYC = pdsp_pkg::NO_REPLY_CYC,
	parameter int unsigned REPLY_WAIT_CYC = pdsp_pkg::REPLY_WAIT_CYC,
	parameter int unsigned IDENTITY_CYC = pdsp_pkg::IDENTITY_DISCOVERY_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic hard_reset_detected,
	input wire logic rx_request,
	input wire logic rx_get_source_cap,
	input wire logic rx_sink_caps,
	input wire logic tx_done,
	input wire logic protocol_error,
	input wire logic rx_error_pending,
	input wire logic startup_done,
	input wire logic disable_req,
	input wire logic dpm_eval_valid,
	input wire logic [1:0] dpm_eval,
	input wire logic dpm_caps_changed,
	input wire logic dpm_goto_min_req,
	input wire logic dpm_get_sink_caps,
	input wire logic dpm_ping_req,
	input wire logic dpm_supply_ready,
	input wire logic dpm_supply_default,
	input wire logic explicit_contract,
	input wire logic contract_valid,
	input wire logic needs_cable_plug,
	input wire logic identity_ack,
	input wire logic no_reply_stop,
	output pdsp_pkg::pdsp_state_e src_state,
	output logic tx_req,
	output pdsp_pkg::pdsp_msg_e tx_msg,
	output logic dpm_eval_req,
	output logic supply_change_req,
	output logic sequence_end,
	output logic hard_reset_tx_req,
	output logic [pdsp_pkg::HR_COUNT_W-1:0] hard_reset_count,
	output logic supply_hard_reset_req,
	output logic local_reset_req,
	output logic downstream_facing_port,
	output logic conductor_power_on,
	output logic hard_reset_done,
	output logic sink_caps_done,
	output logic sink_caps_timeout,
	output logic no_reply_timeout,
	output logic identity_timeout,
	output logic default_power
);
	localparam int unsigned TW = pdsp_pkg::TIMER_W;

	pdsp_pkg::pdsp_state_e next_state;
	logic entering;
	logic sent_wait;
	logic trans_asked;
	logic query_armed;
	logic st_exp, hrs_exp, nr_exp, rw_exp, id_exp;
	logic st_load, hrs_load, nr_load, rw_load, id_load;

	assign entering = (next_state != src_state);

	// next-state choice; protocol events ahead of timers ahead of manager
	always_comb begin
		next_state = src_state;
		if (hard_reset_detected) begin
			next_state = pdsp_pkg::src_hard_reset_rcvd_state;
		end else begin
			case (src_state)
			pdsp_pkg::src_startup_state: begin
				if (disable_req)
					next_state = pdsp_pkg::src_disabled_state;
				else if (startup_done)
					next_state = pdsp_pkg::src_send_caps_state;
			end
			pdsp_pkg::src_send_caps_state: begin
				if (rx_request)
					next_state = pdsp_pkg::src_negotiate_state;
			end
			pdsp_pkg::src_negotiate_state: begin
				if (dpm_eval_valid) begin
					if (dpm_eval == pdsp_pkg::EVAL_CAN_MEET)
						next_state = pdsp_pkg::src_supply_transition_state;
					else
						next_state = pdsp_pkg::src_cap_response_state;
				end
			end
			pdsp_pkg::src_supply_transition_state: begin
				if (protocol_error)
					next_state = pdsp_pkg::src_hard_reset_state;
				else if (trans_asked && dpm_supply_ready)
					next_state = pdsp_pkg::src_ready_state;
			end
			pdsp_pkg::src_ready_state: begin
				if (rx_request)
					next_state = pdsp_pkg::src_negotiate_state;
				else if (rx_get_source_cap || dpm_caps_changed)
					next_state = pdsp_pkg::src_send_caps_state;
				else if (dpm_goto_min_req)
					next_state = pdsp_pkg::src_supply_transition_state;
				else if (dpm_get_sink_caps)
					next_state = pdsp_pkg::src_query_sink_caps_state;
			end
			pdsp_pkg::src_disabled_state: begin
				next_state = pdsp_pkg::src_disabled_state;
			end
			pdsp_pkg::src_cap_response_state: begin
				if (tx_done) begin
					if (!explicit_contract)
						next_state = pdsp_pkg::src_wait_new_caps_state;
					else if (sent_wait || contract_valid)
						next_state = pdsp_pkg::src_ready_state;
					else
						next_state = pdsp_pkg::src_hard_reset_state;
				end
			end
			pdsp_pkg::src_hard_reset_state, pdsp_pkg::src_hard_reset_rcvd_state: begin
				if (hrs_exp)
					next_state = pdsp_pkg::src_return_default_state;
			end
			pdsp_pkg::src_return_default_state: begin
				if (dpm_supply_default)
					next_state = pdsp_pkg::src_startup_state;
			end
			pdsp_pkg::src_query_sink_caps_state: begin
				if (rx_sink_caps || rw_exp)
					next_state = pdsp_pkg::src_ready_state;
			end
			pdsp_pkg::src_wait_new_caps_state: begin
				if (dpm_caps_changed)
					next_state = pdsp_pkg::src_send_caps_state;
			end
			default: next_state = pdsp_pkg::src_startup_state;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			src_state <= pdsp_pkg::src_startup_state;
		else
			src_state <= next_state;
	end

	// messages handed to the protocol layer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_req <= 1'b0;
			tx_msg <= pdsp_pkg::msg_none;
			sent_wait <= 1'b0;
		end else begin
			tx_req <= 1'b0;
			if (entering) begin
				case (next_state)
				pdsp_pkg::src_send_caps_state: begin
					tx_req <= 1'b1;
					tx_msg <= pdsp_pkg::msg_source_caps;
				end
				pdsp_pkg::src_supply_transition_state: begin
					tx_req <= 1'b1;
					tx_msg <= (src_state == pdsp_pkg::src_ready_state) ?
						pdsp_pkg::msg_goto_min : pdsp_pkg::msg_accept;
				end
				pdsp_pkg::src_cap_response_state: begin
					tx_req <= 1'b1;
					if (dpm_eval == pdsp_pkg::EVAL_MEET_LATER && contract_valid) begin
						tx_msg <= pdsp_pkg::msg_wait;
						sent_wait <= 1'b1;
					end else begin
						tx_msg <= pdsp_pkg::msg_reject;
						sent_wait <= 1'b0;
					end
				end
				pdsp_pkg::src_query_sink_caps_state: begin
					tx_req <= 1'b1;
					tx_msg <= pdsp_pkg::msg_get_sink_cap;
				end
				pdsp_pkg::src_ready_state: begin
					if (src_state == pdsp_pkg::src_supply_transition_state) begin
						tx_req <= 1'b1;
						tx_msg <= pdsp_pkg::msg_ps_rdy;
					end
				end
				default: ;
				endcase
			end else if (src_state == pdsp_pkg::src_ready_state && dpm_ping_req) begin
				tx_req <= 1'b1;
				tx_msg <= pdsp_pkg::msg_ping;
			end
		end
	end

	// requests and indications to the policy manager and protocol layer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dpm_eval_req <= 1'b0;
			sequence_end <= 1'b0;
			hard_reset_tx_req <= 1'b0;
			supply_hard_reset_req <= 1'b0;
			local_reset_req <= 1'b0;
			hard_reset_done <= 1'b0;
			sink_caps_done <= 1'b0;
			sink_caps_timeout <= 1'b0;
		end else begin
			dpm_eval_req <= entering && next_state == pdsp_pkg::src_negotiate_state;
			sequence_end <= entering && next_state == pdsp_pkg::src_ready_state
				&& !rx_error_pending;
			hard_reset_tx_req <= entering && next_state == pdsp_pkg::src_hard_reset_state;
			supply_hard_reset_req <= entering
				&& next_state == pdsp_pkg::src_return_default_state;
			local_reset_req <= entering && next_state == pdsp_pkg::src_return_default_state;
			hard_reset_done <= entering && src_state == pdsp_pkg::src_return_default_state;
			sink_caps_done <= entering && src_state == pdsp_pkg::src_query_sink_caps_state;
			if (entering && src_state == pdsp_pkg::src_query_sink_caps_state)
				sink_caps_timeout <= !rx_sink_caps;
		end
	end

	// connector-facing levels
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			downstream_facing_port <= 1'b1;
			conductor_power_on <= 1'b1;
			default_power <= 1'b1;
		end else begin
			if (entering && next_state == pdsp_pkg::src_return_default_state) begin
				downstream_facing_port <= 1'b1;
				conductor_power_on <= 1'b0;
			end else if (entering && src_state == pdsp_pkg::src_return_default_state) begin
				conductor_power_on <= 1'b1;
			end
			default_power <= next_state == pdsp_pkg::src_disabled_state
				|| next_state == pdsp_pkg::src_startup_state;
		end
	end

	// hard reset count holds across hard resets, saturating
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			hard_reset_count <= '0;
		else if (entering && next_state == pdsp_pkg::src_hard_reset_state && !(&hard_reset_count))
			hard_reset_count <= hard_reset_count + 1'b1;
	end

	// supply-transition and query sub-phases
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			trans_asked <= 1'b0;
			supply_change_req <= 1'b0;
			query_armed <= 1'b0;
		end else begin
			supply_change_req <= st_exp && src_state == pdsp_pkg::src_supply_transition_state;
			if (entering)
				trans_asked <= 1'b0;
			else if (st_exp)
				trans_asked <= 1'b1;
			if (entering)
				query_armed <= 1'b0;
			else if (rw_load)
				query_armed <= 1'b1;
		end
	end

	assign st_load = entering && next_state == pdsp_pkg::src_supply_transition_state;
	assign hrs_load = entering && (next_state == pdsp_pkg::src_hard_reset_state
		|| next_state == pdsp_pkg::src_hard_reset_rcvd_state);
	assign nr_load = entering && src_state == pdsp_pkg::src_return_default_state;
	assign rw_load = src_state == pdsp_pkg::src_query_sink_caps_state && tx_done
		&& !query_armed && !entering;
	assign id_load = entering && next_state == pdsp_pkg::src_ready_state
		&& needs_cable_plug;

	pdsp_timer #(.W(TW)) u_src_trans (.clock(clock), .resetn(resetn), .load(st_load),
		.stop(1'b0), .load_val(TW'(SRC_TRANS_CYC)), .running(), .expired(st_exp));
	pdsp_timer #(.W(TW)) u_hr_supply (.clock(clock), .resetn(resetn), .load(hrs_load),
		.stop(1'b0), .load_val(TW'(HR_SUPPLY_CYC)), .running(), .expired(hrs_exp));
	// no-reply timer is never stopped by a state change
	pdsp_timer #(.W(TW)) u_no_reply (.clock(clock), .resetn(resetn), .load(nr_load),
		.stop(no_reply_stop), .load_val(TW'(NO_REPLY_CYC)), .running(), .expired(nr_exp));
	pdsp_timer #(.W(TW)) u_reply_wait (.clock(clock), .resetn(resetn), .load(rw_load),
		.stop(1'b0), .load_val(TW'(REPLY_WAIT_CYC)), .running(), .expired(rw_exp));
	pdsp_timer #(.W(TW)) u_identity (.clock(clock), .resetn(resetn), .load(id_load),
		.stop(identity_ack), .load_val(TW'(IDENTITY_CYC)), .running(), .expired(id_exp));

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			no_reply_timeout <= 1'b0;
			identity_timeout <= 1'b0;
		end else begin
			no_reply_timeout <= nr_exp;
			identity_timeout <= id_exp;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_eval_on_entry;
		(src_state == pdsp_pkg::src_negotiate_state
			&& $past(src_state) != pdsp_pkg::src_negotiate_state) |-> dpm_eval_req;
	endproperty
	a_eval_on_entry: assert property (p_eval_on_entry)
		else $error("negotiation entered without evaluation request");

	property p_goto_min_from_ready;
		(src_state == pdsp_pkg::src_supply_transition_state
			&& $past(src_state) == pdsp_pkg::src_ready_state)
			|-> tx_req && tx_msg == pdsp_pkg::msg_goto_min;
	endproperty
	a_goto_min_from_ready: assert property (p_goto_min_from_ready)
		else $error("minimum-power transition did not send GotoMin");

	property p_ps_rdy_on_exit;
		(src_state == pdsp_pkg::src_ready_state
			&& $past(src_state) == pdsp_pkg::src_supply_transition_state)
			|-> tx_req && tx_msg == pdsp_pkg::msg_ps_rdy;
	endproperty
	a_ps_rdy_on_exit: assert property (p_ps_rdy_on_exit)
		else $error("supply transition left without PS_RDY");

	property p_sequence_end;
		(src_state == pdsp_pkg::src_ready_state && $past(src_state) != pdsp_pkg::src_ready_state)
			|-> sequence_end == !$past(rx_error_pending);
	endproperty
	a_sequence_end: assert property (p_sequence_end)
		else $error("end of sequence notice wrong on ready entry");

	property p_disabled_stays;
		(src_state == pdsp_pkg::src_disabled_state && !hard_reset_detected)
			|=> src_state == pdsp_pkg::src_disabled_state;
	endproperty
	a_disabled_stays: assert property (p_disabled_stays)
		else $error("disabled state left without hard reset");

	property p_wait_needs_valid;
		(tx_req && tx_msg == pdsp_pkg::msg_wait) |-> $past(contract_valid);
	endproperty
	a_wait_needs_valid: assert property (p_wait_needs_valid)
		else $error("Wait sent while contract invalid");

	property p_hr_count_up;
		(src_state == pdsp_pkg::src_hard_reset_state
			&& $past(src_state) != pdsp_pkg::src_hard_reset_state)
			|-> hard_reset_tx_req && (hard_reset_count == $past(hard_reset_count) + 1'b1
			|| &$past(hard_reset_count));
	endproperty
	a_hr_count_up: assert property (p_hr_count_up)
		else $error("hard reset entry did not signal and count");

	property p_hr_received;
		hard_reset_detected |=> src_state == pdsp_pkg::src_hard_reset_rcvd_state;
	endproperty
	a_hr_received: assert property (p_hr_received)
		else $error("detected hard reset not followed");

	property p_default_entry;
		(src_state == pdsp_pkg::src_return_default_state
			&& $past(src_state) != pdsp_pkg::src_return_default_state)
			|-> !conductor_power_on && downstream_facing_port && supply_hard_reset_req && local_reset_req;
	endproperty
	a_default_entry: assert property (p_default_entry)
		else $error("return-to-default entry actions missing");

	property p_default_exit;
		($past(src_state) == pdsp_pkg::src_return_default_state
			&& src_state == pdsp_pkg::src_startup_state)
			|-> conductor_power_on && hard_reset_done;
	endproperty
	a_default_exit: assert property (p_default_exit)
		else $error("return-to-default exit actions missing");

	property p_query_outcome;
		($past(src_state) == pdsp_pkg::src_query_sink_caps_state
			&& src_state == pdsp_pkg::src_ready_state) |-> sink_caps_done;
	endproperty
	a_query_outcome: assert property (p_query_outcome)
		else $error("sink capability query outcome not reported");

	c_reach_ready: cover property (src_state == pdsp_pkg::src_ready_state);
	c_hard_reset: cover property (hard_reset_done);
	c_wait_new: cover property (src_state == pdsp_pkg::src_wait_new_caps_state);
	c_query_timeout: cover property (sink_caps_done && sink_caps_timeout);

endmodule
`default_nettype wire

/* File: verification/pdsp_sink_model.sv */
// Purpose: far-side sink as seen through the protocol layer
// Assumes: same clock as the engine
// Notes: acknowledges each sent message after a set delay
`timescale 1ns/100ps
`default_nettype none
module pdsp_sink_model (
	input wire logic clock,
	input wire logic resetn,
	input wire logic tx_req,
	input wire pdsp_pkg::pdsp_msg_e tx_msg,
	input wire logic [2:0] delay,
	input wire logic give_caps,
	output logic tx_done,
	output logic rx_sink_caps
);
	logic [3:0] cnt;
	logic caps_due;
	// capabilities follow one cycle after the send is reported
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt <= 4'h0;
			caps_due <= 1'b0;
			tx_done <= 1'b0;
			rx_sink_caps <= 1'b0;
		end else begin
			if (tx_req) begin
				cnt <= {1'b0, delay} + 4'h1;
				caps_due <= give_caps && tx_msg == pdsp_pkg::msg_get_sink_cap;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
			tx_done <= cnt == 4'h1 && !tx_req;
			rx_sink_caps <= tx_done && caps_due;
		end
	end
endmodule
`default_nettype wire

/* File: verification/pd_source_policy_states_bench.sv */
// Purpose: self-checking bench for the source policy engine
// Assumes: short timer parameters
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module pd_source_policy_states_bench;
	localparam int TS = 8, HR = 20;
	logic clock, resetn, hard_reset_detected, rx_request, rx_get_source_cap, rx_sink_caps;
	logic tx_done, protocol_error, rx_error_pending, startup_done, disable_req, dpm_eval_valid;
	logic [1:0] dpm_eval;
	logic dpm_caps_changed, dpm_goto_min_req, dpm_get_sink_caps, dpm_ping_req, dpm_supply_ready;
	logic dpm_supply_default, explicit_contract, contract_valid, needs_cable_plug, identity_ack;
	logic no_reply_stop, tx_req, dpm_eval_req, supply_change_req, sequence_end, hard_reset_tx_req;
	logic supply_hard_reset_req, local_reset_req, downstream_facing_port, conductor_power_on;
	logic hard_reset_done, sink_caps_done, sink_caps_timeout, no_reply_timeout;
	logic identity_timeout, default_power, give_caps;
	logic [3:0] hard_reset_count;
	logic [2:0] delay;
	pdsp_pkg::pdsp_state_e src_state;
	pdsp_pkg::pdsp_msg_e tx_msg;
	int miscompares = 0, cmp_count = 0, hr_exp = 0, idn = 0, nrn = 0, n;
	integer seed;
	pdsp_engine #(.SRC_TRANS_CYC(TS), .HR_SUPPLY_CYC(HR), .NO_REPLY_CYC(30), .REPLY_WAIT_CYC(40),
		.IDENTITY_CYC(10)) dut (.clock, .resetn, .hard_reset_detected, .rx_request,
		.rx_get_source_cap, .rx_sink_caps, .tx_done, .protocol_error, .rx_error_pending,
		.startup_done, .disable_req, .dpm_eval_valid, .dpm_eval, .dpm_caps_changed,
		.dpm_goto_min_req, .dpm_get_sink_caps, .dpm_ping_req, .dpm_supply_ready,
		.dpm_supply_default, .explicit_contract, .contract_valid, .needs_cable_plug,
		.identity_ack, .no_reply_stop, .src_state, .tx_req, .tx_msg, .dpm_eval_req,
		.supply_change_req, .sequence_end, .hard_reset_tx_req, .hard_reset_count,
		.supply_hard_reset_req, .local_reset_req, .downstream_facing_port, .conductor_power_on,
		.hard_reset_done, .sink_caps_done, .sink_caps_timeout, .no_reply_timeout,
		.identity_timeout, .default_power);
	pdsp_sink_model far (.clock, .resetn, .tx_req, .tx_msg, .delay, .give_caps, .tx_done,
		.rx_sink_caps);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(negedge clock) begin
		idn += int'(identity_timeout === 1'b1);
		nrn += int'(no_reply_timeout === 1'b1);
	end
	function automatic pdsp_pkg::pdsp_msg_e exp_msg(input logic cv, input logic [1:0] ev);
		return (ev == pdsp_pkg::EVAL_MEET_LATER && cv) ? pdsp_pkg::msg_wait : pdsp_pkg::msg_reject;
	endfunction
	function automatic pdsp_pkg::pdsp_state_e exp_next(input logic ec, cv, input logic [1:0] ev);
		if (!ec)
			return pdsp_pkg::src_wait_new_caps_state;
		return (cv) ? pdsp_pkg::src_ready_state : pdsp_pkg::src_hard_reset_state;
	endfunction
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input bit ok, input string m);
		cmp_count++;
		if (!ok) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	task automatic wait_state(input pdsp_pkg::pdsp_state_e s, input int lim);
		n = 0;
		while (src_state !== s && n < lim) begin
			@(negedge clock);
			n++;
		end
		if (src_state !== s) begin
			check(1'b0, "state wait ran out");
			stop_test();
		end
	endtask
	task automatic negotiate(input logic [1:0] ev);
		pulse(rx_request);
		check(src_state === pdsp_pkg::src_negotiate_state && dpm_eval_req === 1'b1, "eval");
		dpm_eval = ev;
		pulse(dpm_eval_valid);
	endtask
	task automatic to_ready(input logic err, input pdsp_pkg::pdsp_msg_e m);
		check(tx_req === 1'b1 && tx_msg === m, "supply entry message");
		n = 0;
		while (supply_change_req !== 1'b1 && n < TS + 4) begin
			@(negedge clock);
			n++;
		end
		check(supply_change_req === 1'b1 && n >= TS, "supply change delay");
		if (supply_change_req !== 1'b1)
			stop_test();
		rx_error_pending = err;
		pulse(dpm_supply_ready);
		rx_error_pending = 1'b0;
		check(src_state === pdsp_pkg::src_ready_state
			&& tx_msg === pdsp_pkg::msg_ps_rdy, "rdy");
		check(sequence_end === !err, "sequence end notice");
	endtask
	task automatic recover(input bit sig);
		if (sig) begin
			pulse(hard_reset_detected);
			check(src_state === pdsp_pkg::src_hard_reset_rcvd_state, "receipt");
		end
		wait_state(pdsp_pkg::src_return_default_state, HR + 4);
		check(supply_hard_reset_req & local_reset_req & downstream_facing_port
			& !conductor_power_on, "d");
		pulse(dpm_supply_default);
		check(src_state === pdsp_pkg::src_startup_state
			&& (hard_reset_done & conductor_power_on) === 1'b1, "default exit");
		pulse(startup_done);
	endtask
	initial begin
		{hard_reset_detected, rx_request, rx_get_source_cap, protocol_error, rx_error_pending} = '0;
		{startup_done, disable_req, dpm_eval_valid, dpm_eval, dpm_caps_changed} = '0;
		{dpm_goto_min_req, dpm_get_sink_caps, dpm_ping_req, dpm_supply_ready} = '0;
		{dpm_supply_default, identity_ack, no_reply_stop} = '0;
		{explicit_contract, contract_valid, needs_cable_plug, give_caps} = 4'hf;
		seed = 32'h0fb15454;
		delay = 3'h2;
		resetn = 1'b0;
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		check(src_state === pdsp_pkg::src_startup_state
			&& (default_power & downstream_facing_port) === 1'b1, "rst");
		pulse(startup_done);
		negotiate(pdsp_pkg::EVAL_CAN_MEET);
		to_ready(1'b0, pdsp_pkg::msg_accept);
		n = idn;
		pulse(identity_ack);
		repeat (12) @(negedge clock);
		check(idn == n, "identity timer stop");
		pulse(dpm_ping_req);
		check(src_state === pdsp_pkg::src_ready_state
			&& tx_msg === pdsp_pkg::msg_ping, "ping");
		pulse(dpm_goto_min_req);
		check(src_state === pdsp_pkg::src_supply_transition_state, "minimum power");
		to_ready(1'b1, pdsp_pkg::msg_goto_min);
		$display("test accept and minimum power done");
		repeat (2) begin
			pulse(dpm_get_sink_caps);
			check(tx_msg === pdsp_pkg::msg_get_sink_cap, "query sent");
			wait_state(pdsp_pkg::src_ready_state, 60);
			check(sink_caps_done === 1'b1 && sink_caps_timeout === !give_caps, "query outcome");
			give_caps = 1'b0;
		end
		$display("test sink query done");
		negotiate(pdsp_pkg::EVAL_CAN_MEET);
		@(negedge clock);
		pulse(protocol_error);
		hr_exp++;
		check(src_state === pdsp_pkg::src_hard_reset_state
			&& hard_reset_count === 4'(hr_exp), "pe");
		recover(1'b0);
		for (int i = 0; i < 10; i++) begin
			delay = 3'($random(seed));
			explicit_contract = 1'($random(seed));
			contract_valid = 1'($random(seed));
			negotiate(2'h1 + 2'($random(seed) & 1));
			check(tx_msg === exp_msg(contract_valid, dpm_eval), "response message");
			wait_state(exp_next(explicit_contract, contract_valid, dpm_eval), 12);
			if (src_state === pdsp_pkg::src_ready_state)
				pulse(rx_get_source_cap);
			else if (src_state === pdsp_pkg::src_wait_new_caps_state)
				pulse(dpm_caps_changed);
			else begin
				hr_exp++;
				check(hard_reset_tx_req === 1'b1 && hard_reset_count === 4'(hr_exp), "count");
				recover(1'b0);
			end
			check(src_state === pdsp_pkg::src_send_caps_state, "capabilities resent");
		end
		$display("test capability response done");
		recover(1'b1);
		n = nrn;
		repeat (32) @(negedge clock);
		check(nrn == n + 1, "no-reply expiry");
		recover(1'b1);
		pulse(hard_reset_detected);
		wait_state(pdsp_pkg::src_return_default_state, HR + 4);
		pulse(dpm_supply_default);
		pulse(disable_req);
		pulse(rx_request);
		check(src_state === pdsp_pkg::src_disabled_state
			&& default_power === 1'b1, "disabled");
		recover(1'b1);
		check(idn > 0 && nrn > 0, "timers expired");
		n = nrn;
		pulse(no_reply_stop);
		repeat (32) @(negedge clock);
		check(nrn == n, "no-reply timer stop");
		$display("test hard reset and disabled done");
		stop_test();
	end
	initial begin
		repeat (20000) @(negedge clock);
		check(1'b0, "run too long");
		stop_test();
	end
endmodule
`default_nettype wire
